// ### rtl/smsp_pkg.sv
// Constants, register map and shared helpers of the serial master/slave port.
// Assumes the port is reached over a 32-bit APB with one word per register.
package smsp_pkg;
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_CLKDIV = 8'h10;
  localparam int C1_RXIE = 7;
  localparam int C1_EN = 6;
  localparam int C1_TXIE = 5;
  localparam int C1_MASTER_SELECT_BIT = 4;
  localparam int C1_CPOL = 3;
  localparam int C1_CPHA = 2;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;
  localparam int C1_LSBF = 0;
  localparam int C2_FAULT_DETECT_ENABLE = 4;
  localparam int C2_BIDIROE = 3;
  localparam int C2_SPC0 = 0;
  localparam int ST_RXF = 7;
  localparam int ST_TXE = 5;
  localparam int ST_MASTER_FAULT_FLAG = 4;
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CLKDIV_RST = 8'h03;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam int PIN_SCK = 3;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 1;
  localparam int PIN_SSN = 0;

  // Shifts one received bit into the byte in the chosen order.
  function automatic logic [7:0] smsp_shift_in(input logic [7:0] sh,
                                               input logic inBit,
                                               input logic lsbFirst);
    smsp_shift_in = lsbFirst ? {inBit, sh[7:1]} : {sh[6:0], inBit};
  endfunction : smsp_shift_in

  // Bit of the byte that goes out next.
  function automatic logic smsp_top_bit(input logic [7:0] sh,
                                        input logic lsbFirst);
    smsp_top_bit = lsbFirst ? sh[0] : sh[7];
  endfunction : smsp_top_bit
endpackage : smsp_pkg

// ### rtl/smsp_if.sv
// Serial link between the port and its partner, with pin resolution.
// Each pin is output plus active-low enable per end; undriven lines pull high.
`timescale 1ns/1ps
interface smsp_if;
  logic devSckO, devSckOeN, devMosiO, devMosiOeN;
  logic devMisoO, devMisoOeN, devSsnO, devSsnOeN;
  logic parSckO, parSckOeN, parMosiO, parMosiOeN;
  logic parMisoO, parMisoOeN, parSsnO, parSsnOeN;
  logic sck, mosi, miso, ssN;

  assign sck = !devSckOeN ? devSckO : (!parSckOeN ? parSckO : 1'b1);
  assign mosi = !devMosiOeN ? devMosiO : (!parMosiOeN ? parMosiO : 1'b1);
  assign miso = !devMisoOeN ? devMisoO : (!parMisoOeN ? parMisoO : 1'b1);
  assign ssN = !devSsnOeN ? devSsnO : (!parSsnOeN ? parSsnO : 1'b1);

  modport device (
    output devSckO, devSckOeN, devMosiO, devMosiOeN,
    output devMisoO, devMisoOeN, devSsnO, devSsnOeN,
    input sck, mosi, miso, ssN
  );
  modport partner (
    output parSckO, parSckOeN, parMosiO, parMosiOeN,
    output parMisoO, parMisoOeN, parSsnO, parSsnOeN,
    input sck, mosi, miso, ssN
  );
endinterface : smsp_if

// ### rtl/smsp_partner.sv
// Far end of the link: a plain byte master or slave driven by user logic.
// Assumes full-duplex wiring and the same clock mode as the port.
`timescale 1ns/1ps
module smsp_partner #(
  parameter logic [7:0] HALF_CYCLES = 8'h05
) (
  input wire logic clk_sys,
  input wire logic rst,
  smsp_if.partner link,
  input wire logic asMaster,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsbFirst,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid
);
  typedef struct packed {
    logic [3:0] s1, s2, s3;
    logic [7:0] sh, rxData, divCnt;
    logic [4:0] edgeCnt;
    logic busy, sckQ, outQ, rxValid, selHold;
  } smsp_par_s;

  smsp_par_s q, d;
  logic sckEdge, selLow;

  always_comb begin
    d = q;
    d.s1 = {link.sck, link.mosi, link.miso, link.ssN};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rxValid = 1'b0;
    d.selHold = q.busy;
    sckEdge = 1'b0;
    selLow = !q.s2[smsp_pkg::PIN_SSN];
    // Select is held one cycle past the last edge, then released one cycle.
    if (txValid && !q.busy && !q.selHold) begin
      d.sh = txData;
      d.busy = 1'b1;
      d.divCnt = HALF_CYCLES;
    end
    if (asMaster) begin
      if (q.busy) begin
        if (q.divCnt == 8'h00) begin
          d.divCnt = HALF_CYCLES;
          d.sckQ = !q.sckQ;
          sckEdge = 1'b1;
        end else begin
          d.divCnt = q.divCnt - 8'h01;
        end
      end else begin
        d.sckQ = cpol;
      end
    end else if (!selLow) begin
      d.edgeCnt = 5'h00;
    end else begin
      sckEdge = q.s2[smsp_pkg::PIN_SCK] ^ q.s3[smsp_pkg::PIN_SCK];
    end
    if (sckEdge) begin
      if (q.edgeCnt[0] == cpha) begin
        d.sh = smsp_pkg::smsp_shift_in(q.sh, asMaster ?
          q.s2[smsp_pkg::PIN_MISO] : q.s2[smsp_pkg::PIN_MOSI], lsbFirst);
      end else begin
        d.outQ = smsp_pkg::smsp_top_bit(q.sh, lsbFirst);
      end
      d.edgeCnt = q.edgeCnt + 5'h01;
      if (d.edgeCnt == smsp_pkg::EDGES_PER_BYTE) begin
        d.edgeCnt = 5'h00;
        d.busy = 1'b0;
        d.rxData = d.sh;
        d.rxValid = 1'b1;
      end
    end
    if (d.edgeCnt == 5'h00) begin
      d.outQ = smsp_pkg::smsp_top_bit(d.sh, lsbFirst);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.s1 <= 4'hf;
      q.s2 <= 4'hf;
      q.s3 <= 4'hf;
    end else begin
      q <= d;
    end
  end

  assign txReady = !(q.busy || q.selHold);
  assign rxData = q.rxData;
  assign rxValid = q.rxValid;
  assign link.parSckO = q.sckQ;
  assign link.parSckOeN = !asMaster;
  assign link.parMosiO = q.outQ;
  assign link.parMosiOeN = !asMaster;
  assign link.parMisoO = q.outQ;
  assign link.parMisoOeN = asMaster || !selLow;
  assign link.parSsnO = !(q.busy || q.selHold);
  assign link.parSsnOeN = !asMaster;
endmodule : smsp_partner

// ### rtl/smsp_port.sv
// Serial master/slave port with double-buffered bytes and an APB slave.
// Assumes APB on clk_sys and link pins arriving asynchronously.
`timescale 1ns/1ps
module smsp_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irqReq,
  smsp_if.device link
);
  typedef struct packed {
    logic [7:0] ctrl1, ctrl2, clkDiv, txBuf, rxBuf, sh, divCnt;
    logic [3:0] s1, s2, s3;
    logic [4:0] edgeCnt;
    logic txFull, rxFull, master_fault_flag, armTx, armRx, armFault;
    logic busy, sckQ, outQ, selHold;
  } smsp_dev_s;

  smsp_dev_s q, d;
  logic acc, mapped, sckEdge, inBit, en, master_select_bit, cpha, lsbf, spc0, selLow;
  logic [7:0] status;

  assign en = q.ctrl1[smsp_pkg::C1_EN];
  assign master_select_bit = q.ctrl1[smsp_pkg::C1_MASTER_SELECT_BIT];
  assign cpha = q.ctrl1[smsp_pkg::C1_CPHA];
  assign lsbf = q.ctrl1[smsp_pkg::C1_LSBF];
  assign spc0 = q.ctrl2[smsp_pkg::C2_SPC0];
  assign selLow = !q.s2[smsp_pkg::PIN_SSN];
  assign acc = psel && penable;

  always_comb begin
    status = 8'h00;
    status[smsp_pkg::ST_RXF] = q.rxFull;
    status[smsp_pkg::ST_TXE] = !q.txFull;
    status[smsp_pkg::ST_MASTER_FAULT_FLAG] = q.master_fault_flag;
  end

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      smsp_pkg::ADDR_CTRL1: prdata[7:0] = q.ctrl1;
      smsp_pkg::ADDR_CTRL2: prdata[7:0] = q.ctrl2;
      smsp_pkg::ADDR_STATUS: prdata[7:0] = status;
      smsp_pkg::ADDR_DATA: prdata[7:0] = q.rxBuf;
      smsp_pkg::ADDR_CLKDIV: prdata[7:0] = q.clkDiv;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  always_comb begin
    d = q;
    d.s1 = {link.sck, link.mosi, link.miso, link.ssN};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.selHold = q.busy;
    sckEdge = 1'b0;
    if (spc0) begin
      inBit = master_select_bit ? q.s2[smsp_pkg::PIN_MOSI] : q.s2[smsp_pkg::PIN_MISO];
    end else begin
      inBit = master_select_bit ? q.s2[smsp_pkg::PIN_MISO] : q.s2[smsp_pkg::PIN_MOSI];
    end

    // Register accesses take effect at the access-phase edge.
    if (acc && !pwrite) begin
      if (paddr == smsp_pkg::ADDR_STATUS) begin
        d.armTx = !q.txFull;
        d.armRx = q.rxFull;
        d.armFault = q.master_fault_flag;
      end
      if (paddr == smsp_pkg::ADDR_DATA && q.armRx) begin
        d.rxFull = 1'b0;
        d.armRx = 1'b0;
      end
    end
    if (acc && pwrite) begin
      case (paddr)
        smsp_pkg::ADDR_CTRL1: begin
          d.ctrl1 = pwdata[7:0];
          if (q.armFault) begin
            d.master_fault_flag = 1'b0;
            d.armFault = 1'b0;
          end
        end
        smsp_pkg::ADDR_CTRL2: d.ctrl2 = pwdata[7:0];
        smsp_pkg::ADDR_CLKDIV: d.clkDiv = pwdata[7:0];
        smsp_pkg::ADDR_DATA: begin
          if (q.armTx && !q.txFull) begin
            d.txBuf = pwdata[7:0];
            d.txFull = 1'b1;
            d.armTx = 1'b0;
          end
        end
        default: d.armTx = q.armTx;
      endcase
    end

    // Queued byte enters the shifter when the port is enabled, the shifter is free and, as master, select has gone high.
    // Select stays low one cycle past the last clock edge and then high for
    // one cycle, so a synchronising slave sees the final edge in its frame.
    if (en && q.txFull && !q.busy &&
        (master_select_bit ? !q.selHold : q.edgeCnt == 5'h00)) begin
      d.sh = q.txBuf;
      d.txFull = 1'b0;
      d.busy = 1'b1;
      d.divCnt = q.clkDiv;
    end

    // Miso passes the input synchronisers, so a master half period shorter
    // than six clk_sys cycles samples a stale bit.
    if (!en) begin
      d.busy = 1'b0;
      d.edgeCnt = 5'h00;
    end else if (master_select_bit) begin
      if (q.busy) begin
        if (q.divCnt == 8'h00) begin
          d.divCnt = q.clkDiv;
          d.sckQ = !q.sckQ;
          sckEdge = 1'b1;
        end else begin
          d.divCnt = q.divCnt - 8'h01;
        end
      end else begin
        d.sckQ = q.ctrl1[smsp_pkg::C1_CPOL];
      end
    end else if (!selLow) begin
      d.edgeCnt = 5'h00;
    end else begin
      sckEdge = q.s2[smsp_pkg::PIN_SCK] ^ q.s3[smsp_pkg::PIN_SCK];
    end

    if (sckEdge) begin
      if (q.edgeCnt[0] == cpha) begin
        d.sh = smsp_pkg::smsp_shift_in(q.sh, inBit, lsbf);
      end else begin
        d.outQ = smsp_pkg::smsp_top_bit(q.sh, lsbf);
      end
      d.edgeCnt = q.edgeCnt + 5'h01;
      if (d.edgeCnt == smsp_pkg::EDGES_PER_BYTE) begin
        d.edgeCnt = 5'h00;
        d.busy = 1'b0;
        if (!q.rxFull || (d.rxFull == 1'b0)) begin
          d.rxBuf = d.sh;
          d.rxFull = 1'b1;
        end
      end
    end

    // A second master pulling select low drops this end to slave.
    if (en && master_select_bit && q.ctrl2[smsp_pkg::C2_FAULT_DETECT_ENABLE] &&
        !q.ctrl1[smsp_pkg::C1_SELECT_OUTPUT_ENABLE] && selLow) begin
      d.master_fault_flag = 1'b1;
      d.ctrl1[smsp_pkg::C1_MASTER_SELECT_BIT] = 1'b0;
      d.busy = 1'b0;
      d.edgeCnt = 5'h00;
    end

    if (d.edgeCnt == 5'h00) begin
      d.outQ = smsp_pkg::smsp_top_bit(d.sh, d.ctrl1[smsp_pkg::C1_LSBF]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.ctrl1 <= smsp_pkg::CTRL1_RST;
      q.ctrl2 <= smsp_pkg::CTRL2_RST;
      q.clkDiv <= smsp_pkg::CLKDIV_RST;
      q.rxBuf <= smsp_pkg::DATA_RST;
      q.txBuf <= smsp_pkg::DATA_RST;
      q.s1 <= 4'hf;
      q.s2 <= 4'hf;
      q.s3 <= 4'hf;
    end else begin
      q <= d;
    end
  end

  // One request line shared by all three flags.
  assign irqReq = (q.ctrl1[smsp_pkg::C1_RXIE] && (q.rxFull || q.master_fault_flag)) ||
                  (q.ctrl1[smsp_pkg::C1_TXIE] && !q.txFull);

  // Drivers follow the mode; a fault leaves only single-wire data alive.
  assign link.devSckO = q.sckQ;
  assign link.devSckOeN = !(en && master_select_bit);
  assign link.devMosiO = q.outQ;
  assign link.devMosiOeN = !(en && master_select_bit &&
    (!spc0 || q.ctrl2[smsp_pkg::C2_BIDIROE]));
  assign link.devMisoO = q.outQ;
  assign link.devMisoOeN = !(en && !master_select_bit && selLow &&
    (spc0 ? q.ctrl2[smsp_pkg::C2_BIDIROE] : !q.master_fault_flag));
  assign link.devSsnO = !(q.busy || q.selHold);
  assign link.devSsnOeN = !(en && master_select_bit && q.ctrl1[smsp_pkg::C1_SELECT_OUTPUT_ENABLE] &&
    q.ctrl2[smsp_pkg::C2_FAULT_DETECT_ENABLE]);
endmodule : smsp_port

// ### tb/smsp_properties.sv
// Wire-level properties of the serial link, seen from the port end.
// Assumes the port's clk_sys and rst and the link signals of the interface.
`timescale 1ns/1ps
module smsp_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic devSckO,
  input wire logic devSckOeN,
  input wire logic devMosiOeN,
  input wire logic devMisoOeN,
  input wire logic devSsnO,
  input wire logic devSsnOeN,
  input wire logic ssN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] edgeCnt_q;
  logic sckLast_q;
  logic ownSel_q;
  logic selOwn;
  assign selOwn = !devSsnOeN && ownSel_q;
  // Counts clock toggles while the port holds its own select low.
  always_ff @(posedge clk_sys) begin
    sckLast_q <= devSckO;
    ownSel_q <= !devSsnOeN;
    if (rst || devSsnOeN || devSsnO) begin
      edgeCnt_q <= 5'h00;
    end else if (devSckO != sckLast_q) begin
      edgeCnt_q <= edgeCnt_q + 5'h01;
    end
  end
  sel_during_clk_a: assert property ((selOwn && $past(!devSckOeN) &&
    $changed(devSckO)) |-> !devSsnO) else $error("clock edge, select high");
  byte_edges_a: assert property ((selOwn && $rose(devSsnO)) |->
    edgeCnt_q == smsp_pkg::EDGES_PER_BYTE) else $error("bad edge count");
  frame_hold_a: assert property ((selOwn && $fell(devSsnO)) |->
    !devSsnO[*8]) else $error("select released early");
  frame_end_a: assert property ((selOwn && $fell(devSsnO)) |->
    ##[1:300] devSsnO) else $error("frame never ends");
  fault_release_a: assert property ((!devSckOeN && devSsnOeN &&
    $fell(ssN)) |-> ##[1:8] (devSckOeN && devMosiOeN))
    else $error("drivers kept after fault");
  fault_silent_a: assert property ((selOwn && $past(!devSckOeN)) |->
    !devSckOeN) else $error("master dropped with own select");
  slave_quiet_a: assert property (devSckOeN |-> devMosiOeN)
    else $error("slave drives mosi");
  master_quiet_a: assert property (!devSckOeN |-> devMisoOeN)
    else $error("master drives miso");
  cover property (selOwn && $fell(devSsnO));
  cover property (devSsnOeN && !devSckOeN && $fell(ssN));
  cover property (devSckOeN && !ssN && $changed(devSckO));
endmodule : smsp_properties

// ### tb/spi_master_slave_port_tb.sv
// Bench joining the port and its partner over the link, driven over APB.
// Assumes the partner's default half period; the APB master waits for pready.
`timescale 1ns/1ps
module spi_master_slave_port_tb;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irqReq, txReady, rxValid, err;
  logic asMaster = 1'h0, cpol = 1'h0, cpha = 1'h0, lsbFirst = 1'h0;
  logic txValid = 1'h0;
  logic [7:0] txData = 8'h00;
  logic [7:0] rxData, r;
  logic [7:0] rxQ[$];
  int error_cnt = 0;
  int cmp_count = 0;
  smsp_if link();
  smsp_port u_smsp_port (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqReq(irqReq),
    .link(link));
  smsp_partner u_smsp_partner (.clk_sys(clk_sys), .rst(rst), .link(link),
    .asMaster(asMaster), .cpol(cpol), .cpha(cpha), .lsbFirst(lsbFirst),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid));
  smsp_properties u_smsp_properties (.clk_sys(clk_sys), .rst(rst),
    .devSckO(link.devSckO), .devSckOeN(link.devSckOeN),
    .devMosiOeN(link.devMosiOeN), .devMisoOeN(link.devMisoOeN),
    .devSsnO(link.devSsnO), .devSsnOeN(link.devSsnOeN), .ssN(link.ssN));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rxValid === 1'h1) rxQ.push_back(rxData);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the answer is taken at the edge that sees pready high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      $display("Error at %0t: bus timeout", $time);
    end
    r = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Lets the effect of the access settle before the caller looks.
    @(negedge clk_sys);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'h0, 8'h00);
    chk(r, exp);
  endtask : rd
  task automatic pushPar(input logic [7:0] d);
    @(posedge clk_sys);
    txData <= d;
    txValid <= 1'h1;
    @(posedge clk_sys);
    txValid <= 1'h0;
  endtask : pushPar
  task automatic waitRx(input int n);
    int k;
    k = 0;
    while (rxQ.size() < n && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    // The port's slave end completes a few cycles after the partner.
    repeat (4) @(posedge clk_sys);
    chk(8'(rxQ.size()), 8'(n));
  endtask : waitRx
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    rd(smsp_pkg::ADDR_CTRL1, smsp_pkg::CTRL1_RST);
    rd(smsp_pkg::ADDR_DATA, 8'h00);
    apb(smsp_pkg::ADDR_DATA, 1'h1, 8'h11);
    rd(smsp_pkg::ADDR_STATUS, 8'h20);
    apb(8'h14, 1'h0, 8'h00);
    chk({7'h00, err}, 8'h01);
    chk({7'h00, irqReq}, 8'h00);
    apb(smsp_pkg::ADDR_CTRL2, 1'h1, 8'h10);
    rd(smsp_pkg::ADDR_CLKDIV, smsp_pkg::CLKDIV_RST);
    apb(smsp_pkg::ADDR_CLKDIV, 1'h1, 8'h05);
    rd(smsp_pkg::ADDR_CLKDIV, 8'h05);
    apb(smsp_pkg::ADDR_CTRL1, 1'h1, 8'h72);
    chk({7'h00, irqReq}, 8'h01);
    pushPar(8'h3c);
    rd(smsp_pkg::ADDR_STATUS, 8'h20);
    apb(smsp_pkg::ADDR_DATA, 1'h1, 8'ha5);
    rd(smsp_pkg::ADDR_STATUS, 8'h20);
    apb(smsp_pkg::ADDR_DATA, 1'h1, 8'h5a);
    rd(smsp_pkg::ADDR_STATUS, 8'h00);
    chk({7'h00, irqReq}, 8'h00);
    waitRx(2);
    chk(rxQ[0], 8'ha5);
    chk(rxQ[1], 8'h5a);
    rd(smsp_pkg::ADDR_STATUS, 8'ha0);
    rd(smsp_pkg::ADDR_DATA, 8'h3c);
    rd(smsp_pkg::ADDR_STATUS, 8'h20);
    apb(smsp_pkg::ADDR_CTRL1, 1'h1, 8'h50);
    @(posedge clk_sys);
    asMaster <= 1'h1;
    pushPar(8'h69);
    waitRx(3);
    apb(smsp_pkg::ADDR_STATUS, 1'h0, 8'h00);
    chk(r & 8'h10, 8'h10);
    rd(smsp_pkg::ADDR_CTRL1, 8'h40);
    apb(smsp_pkg::ADDR_CTRL1, 1'h1, 8'h40);
    apb(smsp_pkg::ADDR_STATUS, 1'h0, 8'h00);
    chk(r & 8'h10, 8'h00);
    rd(smsp_pkg::ADDR_DATA, 8'h69);
    // Partner as master walks all four clock modes and both bit orders.
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      cpol <= m[1];
      cpha <= m[0];
      lsbFirst <= m[1] ^ m[0];
      apb(smsp_pkg::ADDR_CTRL1, 1'h1, {4'hc, m[1], m[0], 1'h0, m[1] ^ m[0]});
      rd(smsp_pkg::ADDR_STATUS, 8'h20);
      apb(smsp_pkg::ADDR_DATA, 1'h1, {m[1:0], 6'h0d});
      pushPar({6'h2b, m[1:0]});
      waitRx(4 + m);
      chk(rxQ[3 + m], {m[1:0], 6'h0d});
      rd(smsp_pkg::ADDR_STATUS, 8'ha0);
      chk({7'h00, irqReq}, 8'h01);
      rd(smsp_pkg::ADDR_DATA, {6'h2b, m[1:0]});
      chk({7'h00, irqReq}, 8'h00);
    end
    // Single-wire slave drives its byte on miso and reads it back.
    apb(smsp_pkg::ADDR_CTRL2, 1'h1, 8'h09);
    rd(smsp_pkg::ADDR_STATUS, 8'h20);
    apb(smsp_pkg::ADDR_DATA, 1'h1, 8'h96);
    pushPar(8'h00);
    waitRx(8);
    chk(rxQ[7], 8'h96);
    rd(smsp_pkg::ADDR_STATUS, 8'ha0);
    rd(smsp_pkg::ADDR_DATA, 8'h96);
    print_verdict();
  end
endmodule : spi_master_slave_port_tb
